// File: rtl/pcitr_consts.svh
// offsets, field codes and reset values of the transport register bank
`ifndef PCITR_CONSTS_SVH
`define PCITR_CONSTS_SVH

// ==============================================
// bar numbers
`define PCITR_LG_BAR 3'h0
`define PCITR_MEM_BAR 3'h1
`define PCITR_NO_BAR 3'h7
`define PCITR_MAX_BAR 8'h05

// ==============================================
// legacy i/o header, byte offsets
`define PCITR_LG_OFFERED 16'h0000
`define PCITR_LG_ACCFEAT 16'h0004
`define PCITR_LG_QADDR 16'h0008
`define PCITR_LG_QDEPTH 16'h000C
`define PCITR_LG_QSEL 16'h000E
`define PCITR_LG_NOTIFY 16'h0010
`define PCITR_LG_STATUS 16'h0012
`define PCITR_LG_ISR 16'h0013
`define PCITR_LG_CFGVEC 16'h0014
`define PCITR_LG_QVEC 16'h0016
`define PCITR_LG_HDR 16'h0014
`define PCITR_LG_HDR_MSIX 16'h0018

// ==============================================
// memory bar regions, byte offsets
`define PCITR_MEM_ISR 16'h0000
`define PCITR_MEM_STRIDE 16'h0004
`define PCITR_MEM_NLEN 16'h0008
`define PCITR_MEM_NOTIFY 16'h0020
`define PCITR_MEM_DCFG 16'h0040

// ==============================================
// window field codes
`define PCITR_WF_BAR 2'h0
`define PCITR_WF_LEN 2'h1
`define PCITR_WF_OFF 2'h2
`define PCITR_WF_DATA 2'h3

// ==============================================
// cause bits and reset values
`define PCITR_CAUSE_CFG 0
`define PCITR_CAUSE_Q 1
`define PCITR_NO_VECTOR 16'hFFFF
`define PCITR_NUM_QUEUES 2
`define PCITR_QDEPTH 16'h0100
`define PCITR_STRIDE 32'h0000_0004
`define PCITR_DCFG_BYTES 8
`define PCITR_OFFERED 32'h0000_0000
`define PCITR_WIN_LEN_RST 32'h0000_0004

`endif

// File: rtl/pcitr_pkg.sv
// types shared by the transport register bank
package pcitr_pkg;

  // ==============================================
  // device control state, one-hot
  typedef enum logic [1:0] {
    PCITR_RUN = 2'b01,
    PCITR_RST = 2'b10
  } pcitr_fsm_t;

  // ==============================================
  // bar access, from the host or from the window
  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] bar;
    logic [15:0] addr;
    logic [2:0] size;
    logic [31:0] wdata;
  } pcitr_acc_t;

  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } pcitr_rsp_t;

  // config-space window field access
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] field;
    logic [31:0] wdata;
  } pcitr_win_t;

  typedef struct packed {
    logic valid;
    logic [15:0] qidx;
  } pcitr_db_t;

endpackage : pcitr_pkg

// File: rtl/pcitr_db_dec.sv
// doorbell address decoder for the memory notify region
`timescale 1ns/1ns
module pcitr_db_dec #(
  parameter int NQ = 2,
  parameter logic [15:0] BASE = 16'h0020,
  parameter logic [31:0] STRIDE = 32'h0000_0004
) (
  input wire logic [15:0] addr_i,
  output logic hit_o
);
  logic [NQ-1:0] match;

  // ==============================================
  // one compare per queue; the doorbell index of queue q is q
  // a zero stride folds every queue onto the base address
  for (genvar q = 0; q < NQ; q++) begin : g_q
    localparam logic [31:0] QOFF = 32'(q) * STRIDE;
    assign match[q] = (addr_i == BASE + QOFF[15:0]);
  end

  assign hit_o = |match;
endmodule : pcitr_db_dec

// File: rtl/pcitr_regs.sv
// register bank of the pci paravirtual transport: cause, doorbells, window
`timescale 1ns/1ns
`include "pcitr_consts.svh"
module pcitr_regs import pcitr_pkg::*; #(
  parameter int NQ = `PCITR_NUM_QUEUES,
  parameter logic [15:0] QDEPTH = `PCITR_QDEPTH,
  parameter logic [31:0] STRIDE = `PCITR_STRIDE,
  parameter int DCFG_BYTES = `PCITR_DCFG_BYTES,
  parameter logic [31:0] OFFERED = `PCITR_OFFERED
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire pcitr_acc_t bar_req_i,
  output pcitr_rsp_t bar_rsp_o,
  input wire pcitr_win_t cfgw_req_i,
  output pcitr_rsp_t cfgw_rsp_o,
  input wire logic [DCFG_BYTES*8-1:0] dev_cfg_i,
  input wire logic msix_en_i,
  input wire logic intx_mask_i,
  input wire logic cfg_change_evt_i,
  input wire logic queue_evt_i,
  output logic intx_o,
  output logic int_status_o,
  output pcitr_db_t doorbell_o,
  output logic dev_reset_o,
  output logic [63:0] accepted_feat_o
);
  localparam int QW = (NQ > 1) ? $clog2(NQ) : 1;
  // reported notify region length
  localparam logic [31:0] NLEN = 32'(NQ - 1) * STRIDE + 32'h0000_0002;

  // ==============================================
  // whole state of the bank
  typedef struct packed {
    pcitr_fsm_t fsm;
    logic [63:0] acc_feat;
    logic [15:0] qsel;
    logic [15:0] notify;
    logic [7:0] status;
    logic [1:0] cause;
    logic [15:0] cfgvec;
    logic [NQ-1:0][31:0] qbase;
    logic [NQ-1:0][15:0] qvec;
    logic [7:0] win_bar;
    logic [31:0] win_len;
    logic [31:0] win_off;
    logic [31:0] win_data;
    logic pend_rd;
    logic pend_wr;
    pcitr_rsp_t bar_rsp;
    pcitr_rsp_t cfgw_rsp;
    pcitr_db_t db;
    logic intx;
    logic int_status;
    logic dev_reset;
  } pcitr_state_t;

  localparam pcitr_state_t S_RST = '{
    fsm: PCITR_RUN,
    cfgvec: `PCITR_NO_VECTOR,
    qvec: {NQ{`PCITR_NO_VECTOR}},
    win_len: `PCITR_WIN_LEN_RST,
    default: '0
  };

  pcitr_state_t s_r;
  pcitr_state_t s_nxt;
  pcitr_acc_t acc;
  logic src_win;
  logic isr_hit;
  logic isr_rd;
  logic do_reset;
  logic db_hit;
  logic qv;
  logic [QW-1:0] qi;
  logic [1:0] set;
  logic [15:0] hdr;
  logic [31:0] rdata;
  logic [31:0] wd_new;
  logic [191:0] lg;
  logic [127:0] memw;

  // ==============================================
  // memory doorbell decode
  pcitr_db_dec #(
    .NQ(NQ),
    .BASE(`PCITR_MEM_NOTIFY),
    .STRIDE(STRIDE)
  ) u_db_dec (
    .addr_i(acc.addr),
    .hit_o(db_hit)
  );

  // ==============================================
  // selected queue and read images
  assign qv = (s_r.qsel < 16'(NQ));
  assign qi = s_r.qsel[QW-1:0];
  // header grows by the two vector fields while msi-x is on
  assign hdr = msix_en_i ? `PCITR_LG_HDR_MSIX : `PCITR_LG_HDR;
  // little-endian legacy header, first field in the low byte
  assign lg = {
    qv ? s_r.qvec[qi] : `PCITR_NO_VECTOR,
    s_r.cfgvec,
    6'h00, s_r.cause,
    s_r.status,
    s_r.notify,
    s_r.qsel,
    qv ? QDEPTH : 16'h0000,
    qv ? s_r.qbase[qi] : 32'h0000_0000,
    s_r.acc_feat[31:0],
    OFFERED
  };
  // memory bar words: cause, stride, notify length; reserved cause bits zero
  assign memw = {32'h0000_0000, NLEN, STRIDE, 24'h00_0000, 6'h00, s_r.cause};

  // ==============================================
  // access source: host bar requests win, a window access waits for a free cycle
  always_comb begin
    acc = bar_req_i;
    src_win = 1'b0;
    if (!bar_req_i.valid && (s_r.pend_rd || s_r.pend_wr)) begin
      src_win = 1'b1;
      acc.valid = 1'b1;
      acc.write = s_r.pend_wr;
      acc.bar = (s_r.win_bar > `PCITR_MAX_BAR) ? `PCITR_NO_BAR : s_r.win_bar[2:0];
      acc.addr = s_r.win_off[15:0];
      acc.size = s_r.win_len[2:0];
      acc.wdata = s_r.win_data;
    end
  end

  // ==============================================
  // byte-wise read: any width sees the same bytes as natural-width reads
  always_comb begin
    logic [15:0] a;
    logic [15:0] off;
    logic [7:0] b;
    a = '0;
    off = '0;
    b = '0;
    rdata = '0;
    wd_new = s_r.win_data;
    isr_hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < acc.size) begin
        a = acc.addr + 16'(i);
        b = 8'h00;
        if (acc.bar == `PCITR_LG_BAR) begin
          if (a < hdr) begin
            b = lg[int'(a[4:0])*8 +: 8];
          end else begin
            off = a - hdr;
            if (off < 16'(DCFG_BYTES)) begin
              b = dev_cfg_i[int'(off)*8 +: 8];
            end
          end
          if (a == `PCITR_LG_ISR) begin
            isr_hit = 1'b1;
          end
        end else if (acc.bar == `PCITR_MEM_BAR) begin
          if (a < 16'h0010) begin
            b = memw[int'(a[3:0])*8 +: 8];
          end else if (a >= `PCITR_MEM_DCFG) begin
            off = a - `PCITR_MEM_DCFG;
            if (off < 16'(DCFG_BYTES)) begin
              b = dev_cfg_i[int'(off)*8 +: 8];
            end
          end
          if (a == `PCITR_MEM_ISR) begin
            isr_hit = 1'b1;
          end
        end
        rdata[i*8 +: 8] = b;
        wd_new[i*8 +: 8] = b;
      end
    end
  end

  assign isr_rd = acc.valid && !acc.write && isr_hit;
  // a queue event only raises its cause bit while msi-x is off
  assign set = {queue_evt_i && !msix_en_i, cfg_change_evt_i};

  // ==============================================
  // next state
  always_comb begin
    s_nxt = s_r;
    do_reset = 1'b0;
    s_nxt.db.valid = 1'b0;
    s_nxt.bar_rsp = '0;
    s_nxt.cfgw_rsp = '0;
    // read clears, but a same-cycle event survives the clear
    s_nxt.cause = (isr_rd ? 2'b00 : s_r.cause) | set;
    case (s_r.fsm)
      PCITR_RUN: begin
        s_nxt.fsm = PCITR_RUN;
      end
      PCITR_RST: begin
        s_nxt.fsm = PCITR_RUN;
      end
      default: begin
        s_nxt.fsm = PCITR_RUN;
      end
    endcase
    if (bar_req_i.valid) begin
      s_nxt.bar_rsp.valid = 1'b1;
      s_nxt.bar_rsp.rdata = bar_req_i.write ? 32'h0000_0000 : rdata;
    end
    // writes; read-only fields ignore them
    if (acc.valid && acc.write && acc.bar == `PCITR_LG_BAR) begin
      case (acc.addr)
        `PCITR_LG_ACCFEAT: begin
          s_nxt.acc_feat = {32'h0000_0000, acc.wdata};
        end
        `PCITR_LG_QADDR: begin
          if (qv) begin
            s_nxt.qbase[qi] = acc.wdata;
          end
        end
        `PCITR_LG_QSEL: begin
          s_nxt.qsel = acc.wdata[15:0];
        end
        `PCITR_LG_NOTIFY: begin
          s_nxt.notify = acc.wdata[15:0];
          s_nxt.db = '{valid: 1'b1, qidx: acc.wdata[15:0]};
        end
        `PCITR_LG_STATUS: begin
          if (acc.wdata[7:0] == 8'h00) begin
            do_reset = 1'b1;
          end else begin
            s_nxt.status = acc.wdata[7:0];
          end
        end
        `PCITR_LG_CFGVEC: begin
          if (msix_en_i) begin
            s_nxt.cfgvec = acc.wdata[15:0];
          end
        end
        `PCITR_LG_QVEC: begin
          if (msix_en_i && qv) begin
            s_nxt.qvec[qi] = acc.wdata[15:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (acc.valid && acc.write && acc.bar == `PCITR_MEM_BAR && db_hit) begin
      s_nxt.db = '{valid: 1'b1, qidx: acc.wdata[15:0]};
    end
    // device reset is done in one cycle, so state reads zero right after
    if (do_reset) begin
      s_nxt.fsm = PCITR_RST;
      s_nxt.acc_feat = S_RST.acc_feat;
      s_nxt.qsel = S_RST.qsel;
      s_nxt.notify = S_RST.notify;
      s_nxt.status = S_RST.status;
      s_nxt.cause = S_RST.cause;
      s_nxt.cfgvec = S_RST.cfgvec;
      s_nxt.qbase = S_RST.qbase;
      s_nxt.qvec = S_RST.qvec;
    end
    // window access finished: a read lands in the data field
    if (src_win) begin
      s_nxt.pend_rd = 1'b0;
      s_nxt.pend_wr = 1'b0;
      if (s_r.pend_rd) begin
        s_nxt.win_data = wd_new;
      end
      s_nxt.cfgw_rsp = '{valid: 1'b1, rdata: s_r.pend_rd ? wd_new : s_r.win_data};
    end
    // window fields in config space
    if (cfgw_req_i.valid) begin
      case (cfgw_req_i.field)
        `PCITR_WF_BAR: begin
          if (cfgw_req_i.write) begin
            s_nxt.win_bar = cfgw_req_i.wdata[7:0];
          end
          s_nxt.cfgw_rsp = '{valid: 1'b1, rdata: {24'h00_0000, s_nxt.win_bar}};
        end
        `PCITR_WF_LEN: begin
          if (cfgw_req_i.write) begin
            s_nxt.win_len = cfgw_req_i.wdata;
          end
          s_nxt.cfgw_rsp = '{valid: 1'b1, rdata: s_nxt.win_len};
        end
        `PCITR_WF_OFF: begin
          if (cfgw_req_i.write) begin
            s_nxt.win_off = cfgw_req_i.wdata;
          end
          s_nxt.cfgw_rsp = '{valid: 1'b1, rdata: s_nxt.win_off};
        end
        `PCITR_WF_DATA: begin
          if (cfgw_req_i.write) begin
            s_nxt.win_data = cfgw_req_i.wdata;
            s_nxt.pend_wr = 1'b1;
          end else begin
            s_nxt.pend_rd = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // legacy interrupt path follows the new cause value
    s_nxt.int_status = (|s_nxt.cause) && !msix_en_i;
    s_nxt.intx = (|s_nxt.cause) && !msix_en_i && !intx_mask_i;
    s_nxt.dev_reset = (s_nxt.fsm == PCITR_RST);
  end

  // ==============================================
  // state register
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bar_rsp_o = s_r.bar_rsp;
  assign cfgw_rsp_o = s_r.cfgw_rsp;
  assign intx_o = s_r.intx;
  assign int_status_o = s_r.int_status;
  assign doorbell_o = s_r.db;
  assign dev_reset_o = s_r.dev_reset;
  assign accepted_feat_o = s_r.acc_feat;

  // ==============================================
  // checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_isr_quiet;
    isr_rd && set == 2'b00 && !do_reset;
  endsequence
  sequence s_zero_wr;
    acc.valid && acc.write && acc.bar == `PCITR_LG_BAR
      && acc.addr == `PCITR_LG_STATUS && acc.wdata[7:0] == 8'h00;
  endsequence
  sequence s_lg_ring;
    acc.valid && acc.write && acc.bar == `PCITR_LG_BAR && acc.addr == `PCITR_LG_NOTIFY;
  endsequence
  sequence s_win_rd;
    cfgw_req_i.valid && !cfgw_req_i.write && cfgw_req_i.field == `PCITR_WF_DATA;
  endsequence

  a_cause_clear: assert property (s_isr_quiet |=> s_r.cause == 2'b00 && !intx_o)
    else $error("cause byte not cleared by read");
  a_cause_keep: assert property (
    isr_rd && set != 2'b00 && !do_reset |=> (s_r.cause & $past(set)) == $past(set))
    else $error("cause event lost during clearing read");
  a_queue_gate: assert property (
    msix_en_i && !s_r.cause[1] |=> !s_r.cause[1])
    else $error("queue cause set while msi-x on");
  a_cause_first: assert property (
    cfg_change_evt_i && !do_reset && !msix_en_i && !intx_mask_i |=> s_r.cause[0] && intx_o)
    else $error("config change not flagged with interrupt");
  a_intx_or: assert property (
    intx_o == ((|s_r.cause) && !$past(msix_en_i) && !$past(intx_mask_i)))
    else $error("intx does not follow cause bits");
  a_lg_doorbell: assert property (
    s_lg_ring |=> doorbell_o.valid && doorbell_o.qidx == $past(acc.wdata[15:0]))
    else $error("legacy doorbell missed");
  a_mem_doorbell: assert property (
    acc.valid && acc.write && acc.bar == `PCITR_MEM_BAR
      && acc.addr == `PCITR_MEM_NOTIFY |=> doorbell_o.valid)
    else $error("notify region doorbell missed");
  a_zero_state: assert property (
    s_zero_wr |=> dev_reset_o && s_r.status == 8'h00 && s_r.cause == 2'b00 ##1 !dev_reset_o)
    else $error("state zero write did not reset");
  a_win_read: assert property (s_win_rd ##1 !bar_req_i.valid |=> cfgw_rsp_o.valid)
    else $error("window read not answered");
  a_win_write: assert property (
    cfgw_req_i.valid && cfgw_req_i.write && cfgw_req_i.field == `PCITR_WF_DATA
      ##1 !bar_req_i.valid |-> acc.valid && acc.write && acc.wdata == $past(cfgw_req_i.wdata))
    else $error("window write not carried out");
  a_stride_ok: assert property (
    STRIDE == 32'h0 || ((STRIDE & (STRIDE - 32'h1)) == 32'h0
      && (STRIDE & 32'h5555_5555) != 32'h0))
    else $error("doorbell stride not zero or even power");
  a_region_fit: assert property (
    NLEN >= 32'h2 && `PCITR_MEM_NOTIFY % 2 == 0
      && `PCITR_MEM_DCFG % 4 == 0)
    else $error("region offset or length bad");
endmodule : pcitr_regs

// File: sim/pcitr_host.sv
// host driver model: bar and config-window accesses, one at a time
`timescale 1ns/1ns
module pcitr_host import pcitr_pkg::*; (
  input wire logic core_clk_i,
  input wire pcitr_rsp_t bar_rsp_i,
  input wire pcitr_rsp_t cfgw_rsp_i,
  output pcitr_acc_t bar_req_o,
  output pcitr_win_t cfgw_req_o
);
  // ==============================================
  // requests stay idle until the first call
  initial begin
    bar_req_o = '0;
    cfgw_req_o = '0;
  end

  // ==============================================
  // bar access: one-cycle valid, answer taken at the edge where it stands
  // callers never write offered word or queue depth
  task automatic bar(input logic w, input logic [2:0] b, input logic [15:0] a,
      input logic [2:0] s, input logic [31:0] d, output logic [31:0] rd);
    pcitr_acc_t t;
    @(posedge core_clk_i);
    bar_req_o <= '{1'b1, w, b, a, s, d};
    @(posedge core_clk_i);
    // released lines carry inverted junk so stale values never look usable
    t = ~bar_req_o;
    t.valid = 1'b0;
    bar_req_o <= t;
    @(posedge core_clk_i);
    rd = 'x;
    if (bar_rsp_i.valid === 1'b1) begin
      rd = bar_rsp_i.rdata;
    end
  endtask : bar

  // ==============================================
  // window access; a tunnelled one waits for an idle bar cycle, so bounded poll
  task automatic win(input logic w, input logic [1:0] f, input logic [31:0] d,
      output logic [31:0] rd);
    pcitr_win_t t;
    @(posedge core_clk_i);
    cfgw_req_o <= '{1'b1, w, f, d};
    @(posedge core_clk_i);
    t = ~cfgw_req_o;
    t.valid = 1'b0;
    cfgw_req_o <= t;
    rd = 'x;
    for (int i = 0; i < 8; i++) begin
      if (cfgw_rsp_i.valid === 1'b1) begin
        rd = cfgw_rsp_i.rdata;
        break;
      end
      @(posedge core_clk_i);
    end
  endtask : win
endmodule : pcitr_host

// File: sim/testbench.sv
// self-checking bench of the transport register bank
`timescale 1ns/1ns
module testbench import pcitr_pkg::*; ;
  localparam int NQ = 2;
  localparam logic [15:0] QD = 16'h0040;
  localparam logic [31:0] STR = 32'h0000_0004;
  localparam logic [31:0] OFF = 32'h1357_9BDF;
  localparam logic [2:0] LG = 3'h0, MB = 3'h1, B1 = 3'h1, B2 = 3'h2, B4 = 3'h4;
  localparam logic [1:0] FBAR = 2'h0, FLEN = 2'h1, FOFF = 2'h2, FDAT = 2'h3;
  logic clk, rst_n, msix, mask, cevt, qevt, intx, ists, dres;
  logic [63:0] acc;
  logic [63:0] dcfg;
  logic [31:0] rd;
  logic [15:0] last_db;
  pcitr_acc_t breq;
  pcitr_rsp_t brsp, wrsp;
  pcitr_win_t wreq;
  pcitr_db_t db;
  int fail_count, cmp_count, db_cnt, rst_cnt;

  // ==============================================
  // clock and units
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  pcitr_regs #(.NQ(NQ), .QDEPTH(QD), .STRIDE(STR), .DCFG_BYTES(8), .OFFERED(OFF)) u_dut (
    .core_clk_i(clk), .reset_n_i(rst_n), .bar_req_i(breq), .bar_rsp_o(brsp),
    .cfgw_req_i(wreq), .cfgw_rsp_o(wrsp), .dev_cfg_i(dcfg), .msix_en_i(msix),
    .intx_mask_i(mask), .cfg_change_evt_i(cevt), .queue_evt_i(qevt), .intx_o(intx),
    .int_status_o(ists), .doorbell_o(db), .dev_reset_o(dres), .accepted_feat_o(acc));

  pcitr_host u_host (.core_clk_i(clk), .bar_rsp_i(brsp), .cfgw_rsp_i(wrsp),
    .bar_req_o(breq), .cfgw_req_o(wreq));

  // ==============================================
  // pulse monitors: one-cycle outputs are counted where they stand
  always @(posedge clk) begin
    if (db.valid === 1'b1) begin
      db_cnt <= db_cnt + 1;
      last_db <= db.qidx;
    end
    if (dres === 1'b1) rst_cnt <= rst_cnt + 1;
  end

  // ==============================================
  // compare, access and event helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rc(input string nm, input logic [2:0] b, input logic [15:0] a,
      input logic [2:0] s, input logic [31:0] e);
    u_host.bar(1'b0, b, a, s, 32'h0000_0000, rd);
    chk(nm, e, rd);
  endtask : rc

  task automatic wb(input logic [2:0] b, input logic [15:0] a, input logic [2:0] s,
      input logic [31:0] d);
    u_host.bar(1'b1, b, a, s, d, rd);
  endtask : wb

  // write, then let the monitor land; hit tells whether a doorbell must fire
  task automatic dbw(input logic [2:0] b, input logic [15:0] a, input logic [31:0] d,
      input int hit);
    int n;
    n = db_cnt;
    wb(b, a, B2, d);
    @(posedge clk);
    chk("doorbell_count", 32'(n + hit), 32'(db_cnt));
    if (hit == 1) chk("doorbell_index", d, {16'h0000, last_db});
  endtask : dbw

  task automatic ev(input logic q);
    @(posedge clk);
    if (q) qevt <= 1'b1;
    else cevt <= 1'b1;
    @(posedge clk);
    qevt <= 1'b0;
    cevt <= 1'b0;
    @(posedge clk);
  endtask : ev

  task automatic give_verdict;
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  // ==============================================
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  // ==============================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    msix = 1'b0;
    mask = 1'b0;
    cevt = 1'b0;
    qevt = 1'b0;
    dcfg = 64'h8877_6655_4433_2211;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // legacy header layout, msi-x off
    rc("offered", LG, 16'h0000, B4, OFF);
    wb(LG, 16'h0004, B4, 32'hA5A5_0F0F);
    rc("accepted", LG, 16'h0004, B4, 32'hA5A5_0F0F);
    chk("accepted_hi", 32'h0000_0000, acc[63:32]);
    wb(LG, 16'h000E, B2, 32'h0000_0001);
    wb(LG, 16'h0008, B4, 32'h0001_2345);
    rc("qsel", LG, 16'h000E, B2, 32'h0000_0001);
    rc("qaddr1", LG, 16'h0008, B4, 32'h0001_2345);
    rc("depth", LG, 16'h000C, B2, {16'h0000, QD});
    wb(LG, 16'h000E, B2, 32'h0000_0002);
    rc("qaddr_none", LG, 16'h0008, B4, 32'h0000_0000);
    rc("depth_none", LG, 16'h000C, B2, 32'h0000_0000);
    wb(LG, 16'h000E, B2, 32'h0000_0000);
    rc("qaddr0", LG, 16'h0008, B4, 32'h0000_0000);
    dbw(LG, 16'h0010, 32'h0000_0001, 1);
    wb(LG, 16'h0012, B1, 32'h0000_000F);
    rc("state", LG, 16'h0012, B1, 32'h0000_000F);
    // device config at any width, header end moves with msi-x
    rc("dcfg_w32", LG, 16'h0014, B4, 32'h4433_2211);
    rc("dcfg_w8", LG, 16'h0015, B1, 32'h0000_0022);
    rc("dcfg_w16", LG, 16'h0016, B2, 32'h0000_4433);
    rc("dcfg_hi", LG, 16'h0018, B4, 32'h8877_6655);
    @(posedge clk);
    msix <= 1'b1;
    rc("cvec_rst", LG, 16'h0014, B2, 32'h0000_FFFF);
    wb(LG, 16'h0014, B2, 32'h0000_0003);
    wb(LG, 16'h0016, B2, 32'h0000_0005);
    rc("cvec", LG, 16'h0014, B2, 32'h0000_0003);
    rc("qvec", LG, 16'h0016, B2, 32'h0000_0005);
    rc("dcfg_msix", LG, 16'h0018, B4, 32'h4433_2211);
    rc("dcfg_msix8", LG, 16'h001B, B1, 32'h0000_0044);
    wb(LG, 16'h000E, B2, 32'h0000_0002);
    rc("qvec_none", LG, 16'h0016, B2, 32'h0000_FFFF);
    wb(LG, 16'h000E, B2, 32'h0000_0000);
    // a queue event under msi-x must leave cause and intx alone
    ev(1'b1);
    chk("intx_msix", 32'h0, {31'h0, intx});
    chk("status_msix", 32'h0, {31'h0, ists});
    @(posedge clk);
    msix <= 1'b0;
    rc("cause_msix", LG, 16'h0013, B1, 32'h0000_0000);
    // cause byte: set, signal, read-clear
    ev(1'b1);
    chk("intx_q", 32'h1, {31'h0, intx});
    chk("status_q", 32'h1, {31'h0, ists});
    rc("cause_q", LG, 16'h0013, B1, 32'h0000_0002);
    chk("intx_clr", 32'h0, {31'h0, intx});
    rc("cause_clr", LG, 16'h0013, B1, 32'h0000_0000);
    ev(1'b0);
    rc("cause_cfg", MB, 16'h0000, B1, 32'h0000_0001);
    @(posedge clk);
    mask <= 1'b1;
    ev(1'b1);
    chk("intx_mask", 32'h0, {31'h0, intx});
    chk("status_mask", 32'h1, {31'h0, ists});
    ev(1'b0);
    rc("cause_both", MB, 16'h0000, B1, 32'h0000_0003);
    chk("status_clr", 32'h0, {31'h0, ists});
    mask <= 1'b0;
    // event lands in the very cycle of the clearing read
    fork
      rc("cause_race", LG, 16'h0013, B1, 32'h0000_0000);
      begin
        @(posedge clk);
        qevt <= 1'b1;
        @(posedge clk);
        qevt <= 1'b0;
      end
    join
    rc("cause_kept", LG, 16'h0013, B1, 32'h0000_0002);
    // memory bar: stride, length, doorbells, device config
    rc("stride", MB, 16'h0004, B4, STR);
    u_host.bar(1'b0, MB, 16'h0008, B4, 32'h0000_0000, rd);
    chk("db_len", 32'h1, {31'h0, rd >= (NQ - 1) * STR + 2});
    for (int q = 0; q < NQ; q++) begin
      dbw(MB, 16'(32'h0020 + q * STR), 32'(q), 1);
    end
    dbw(MB, 16'h0022, 32'h0000_0001, 0);
    rc("dcfg_mem", MB, 16'h0040, B4, 32'h4433_2211);
    // config window: fields, tunnelled read and write
    u_host.win(1'b0, FLEN, 32'h0000_0000, rd);
    chk("win_len_rst", 32'h0000_0004, rd);
    u_host.win(1'b1, FBAR, 32'h0000_0001, rd);
    chk("win_bar", 32'h0000_0001, rd);
    u_host.win(1'b1, FOFF, 32'h0000_0004, rd);
    u_host.win(1'b0, FDAT, 32'h0000_0000, rd);
    chk("win_rd_stride", STR, rd);
    u_host.win(1'b1, FBAR, 32'h0000_0000, rd);
    u_host.win(1'b1, FLEN, 32'h0000_0001, rd);
    u_host.win(1'b1, FOFF, 32'h0000_0012, rd);
    u_host.win(1'b1, FDAT, 32'hAAAA_AA05, rd);
    rc("win_wr_state", LG, 16'h0012, B1, 32'h0000_0005);
    u_host.win(1'b1, FLEN, 32'h0000_0002, rd);
    u_host.win(1'b1, FOFF, 32'h0000_000C, rd);
    u_host.win(1'b0, FDAT, 32'h0000_0000, rd);
    chk("win_rd_part", {16'hAAAA, QD}, rd);
    // a bar number above the last one tunnels nowhere and reads zero bytes
    u_host.win(1'b1, FBAR, 32'h0000_0006, rd);
    chk("win_bar_hi", 32'h0000_0006, rd);
    u_host.win(1'b0, FDAT, 32'h0000_0000, rd);
    chk("win_rd_nobar", 32'hAAAA_0000, rd);
    // device reset, then the host reads the state back once and expects zero
    wb(LG, 16'h0012, B1, 32'h0000_0000);
    rc("state_zero", LG, 16'h0012, B1, 32'h0000_0000);
    rc("accepted_rst", LG, 16'h0004, B4, 32'h0000_0000);
    chk("reset_pulses", 32'h1, 32'(rst_cnt));
    give_verdict();
  end

  initial begin
    fail_count = 0;
    cmp_count = 0;
    db_cnt = 0;
    rst_cnt = 0;
    last_db = 16'h0000;
  end
endmodule : testbench
